// file: hdl/core_ctx_defs.svh
// constants for the program sequencing and register context block
// assumes inclusion by bare name from the design files
`ifndef CORE_CTX_DEFS_SVH
`define CORE_CTX_DEFS_SVH
`define IP_W 12
`define DATA_W 8
`define STACK_DEPTH 6
`define LVL_W 3
`define PAGE_W 8
`define ADDR_PTR_ONE 8'h80
`define ADDR_PTR_SECOND 8'h81
`define ADDR_SHORT_ONE 8'h82
`define ADDR_SHORT_SECOND 8'h83
`define ADDR_SUM 8'hff
`define VEC_RESET 12'hffe
`define VEC_NMI 12'hffc
`define IP_ZERO 12'h000
`define BYTE_ZERO 8'h00
`define SHORT_DIRECT_CYCLES 3'h4
`define CYC_ZERO 3'h0
`define CYC_ONE 3'h1
`endif

// file: hdl/core_ctx_pkg.sv
// types for the program sequencing and register context block
// assumes the constants header is compiled alongside
package core_ctx_pkg;
    typedef enum logic [1:0] {ctx_main, ctx_irq, ctx_nmi} ctx_e;
    typedef enum logic [2:0] {
        op_none, op_step, op_branch, op_jump, op_call, op_back, op_irq_back
    } ipop_e;
endpackage

// file: hdl/cpu_pc_flags_stack.sv
// program sequencing and register context of an 8-bit core
// assumes the sequencer gives one instr_pointer operation per enabled cycle
//
// Behaviour
// - instr_pointer is 12 bits and names the next fetched program byte.
// - after each fetch instr_pointer advances by one.
// - relative branch adds signed offset to instr_pointer and writes back.
// - jump, call, interrupt, reset and both returns load instr_pointer.
// - program space above 4096 bytes goes through a page register.
// - three carry/zero pairs: main, interrupt, non-maskable interrupt.
// - taking an interrupt selects its pair; irq_back restores the previous.
// - switching contexts never alters any flag pair.
// - instructions see and change only the running context's pair.
// - carry follows carry/borrow, tested bit, or rotate-left out bit.
// - zero is set when the last result is zero, cleared otherwise.
// - reset enters non-maskable interrupt context first.
// - return stack: six 12-bit levels, outside data space, no pointer.
// - call or interrupt shifts levels deeper, instr_pointer into level one.
// - return loads level one into instr_pointer, deeper levels move up.
// - beyond six nestings the stack stays deepest, oldest address lost.
// - return on empty stack leaves it at top; execution continues.
// - 8-bit sum_register is also a data-space location.
// - the two pointer registers are data-space locations.
// - short-direct registers are data-space; short-direct access takes four cycles.
`timescale 1ns/1ns
`include "core_ctx_defs.svh"
module cpu_pc_flags_stack (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input core_ctx_pkg::ipop_e ip_op,
    input wire logic [`IP_W-1:0] target_addr,
    input wire logic [`DATA_W-1:0] branch_offset,
    input wire logic irq_take,
    input wire logic nmi_take,
    input wire logic [`IP_W-1:0] irq_vector,
    input wire logic carry_we,
    input wire logic carry_in,
    input wire logic zero_we,
    input wire logic zero_in,
    input wire logic sum_we,
    input wire logic [`DATA_W-1:0] sum_in,
    input wire logic page_we,
    input wire logic [`PAGE_W-1:0] page_in,
    input wire logic data_we,
    input wire logic data_re,
    input wire logic short_direct,
    input wire logic [7:0] data_addr,
    input wire logic [`DATA_W-1:0] data_wdata,
    output logic [`IP_W-1:0] instr_pointer,
    output logic [`PAGE_W-1:0] prog_page,
    output logic [`DATA_W-1:0] sum_register,
    output logic [`DATA_W-1:0] data_rdata,
    output logic data_hit,
    output logic data_ack,
    output core_ctx_pkg::ctx_e ctx_state,
    output logic carry_flag,
    output logic zero_flag,
    output logic stack_empty
);
    stack_if sif ();
    core_ctx_pkg::ctx_e ctx_r;
    core_ctx_pkg::ctx_e ctx_nxt;
    core_ctx_pkg::ctx_e ctx_prev_r;
    logic [`IP_W-1:0] ip_r;
    logic [`IP_W-1:0] ip_nxt;
    logic [`IP_W-1:0] alu_sum;
    logic [`PAGE_W-1:0] page_r;
    logic [`DATA_W-1:0] sum_r;
    logic [`DATA_W-1:0] ptr_one_r;
    logic [`DATA_W-1:0] ptr_second_r;
    logic [`DATA_W-1:0] short_one_r;
    logic [`DATA_W-1:0] short_second_r;
    logic [`DATA_W-1:0] rdata_r;
    logic hit_r;
    logic ack_r;
    logic [2:0] cyc_r;
    logic carry_cur;
    logic zero_cur;
    logic carry_r;
    logic zero_r;
    logic empty_r;
    logic [2:0] carry_all;
    logic [2:0] zero_all;
    logic take_any;
    logic is_reg;

    ret_stack u_stack (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .sif(sif)
    );

    flag_bank u_flags (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .ctx(ctx_r),
        .carry_we(carry_we),
        .carry_in(carry_in),
        .zero_we(zero_we),
        .zero_in(zero_in),
        .carry_out(carry_cur),
        .zero_out(zero_cur),
        .carry_all(carry_all),
        .zero_all(zero_all)
    );

    // a taken interrupt outranks whatever the sequencer asked for
    assign take_any = irq_take | nmi_take;
    // branch offset is sign-extended and added through the alu path
    assign alu_sum = ip_r + {{(`IP_W-`DATA_W){branch_offset[`DATA_W-1]}}, branch_offset};

    // stack strobes: interrupt entry and call push the pointer, returns pop
    assign sif.push = take_any || ip_op == core_ctx_pkg::op_call;
    assign sif.pop = !take_any && (ip_op == core_ctx_pkg::op_back ||
                                   ip_op == core_ctx_pkg::op_irq_back);
    assign sif.push_data = ip_r;

    // next pointer value
    always_comb begin
        ip_nxt = ip_r;
        if (nmi_take) begin
            ip_nxt = `VEC_NMI;
        end else if (irq_take) begin
            ip_nxt = irq_vector;
        end else begin
            case (ip_op)
                core_ctx_pkg::op_step: ip_nxt = ip_r + `IP_W'(1);
                core_ctx_pkg::op_branch: ip_nxt = alu_sum;
                core_ctx_pkg::op_jump: ip_nxt = target_addr;
                core_ctx_pkg::op_call: ip_nxt = target_addr;
                core_ctx_pkg::op_back,
                core_ctx_pkg::op_irq_back: begin
                    // empty stack: carry on with the following instruction
                    ip_nxt = sif.empty ? ip_r + `IP_W'(1) : sif.top_data;
                end
                default: ip_nxt = ip_r;
            endcase
        end
    end

    // instruction pointer, reset vector on reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ip_r <= `VEC_RESET;
        end else if (clk_en) begin
            ip_r <= ip_nxt;
        end
    end

    // context selection; only one level of return context is remembered
    always_comb begin
        ctx_nxt = ctx_r;
        if (nmi_take) begin
            ctx_nxt = core_ctx_pkg::ctx_nmi;
        end else if (irq_take) begin
            ctx_nxt = core_ctx_pkg::ctx_irq;
        end else if (ip_op == core_ctx_pkg::op_irq_back) begin
            ctx_nxt = ctx_prev_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctx_r <= core_ctx_pkg::ctx_nmi;
            ctx_prev_r <= core_ctx_pkg::ctx_main;
        end else if (clk_en) begin
            ctx_r <= ctx_nxt;
            if (take_any) begin
                ctx_prev_r <= ctx_r;
            end else if (ip_op == core_ctx_pkg::op_irq_back) begin
                ctx_prev_r <= core_ctx_pkg::ctx_main;
            end
        end
    end

    // program page register selects memory above the direct 4096 bytes
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            page_r <= `BYTE_ZERO;
        end else if (clk_en && page_we) begin
            page_r <= page_in;
        end
    end

    assign is_reg = data_addr == `ADDR_SUM || data_addr == `ADDR_PTR_ONE ||
                    data_addr == `ADDR_PTR_SECOND || data_addr == `ADDR_SHORT_ONE ||
                    data_addr == `ADDR_SHORT_SECOND;

    // sum register: alu write-back wins over a data-space write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sum_r <= `BYTE_ZERO;
        end else if (clk_en && sum_we) begin
            sum_r <= sum_in;
        end else if (clk_en && data_we && data_addr == `ADDR_SUM) begin
            sum_r <= data_wdata;
        end
    end

    // pointer and short-direct registers as data-space locations
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ptr_one_r <= `BYTE_ZERO;
            ptr_second_r <= `BYTE_ZERO;
            short_one_r <= `BYTE_ZERO;
            short_second_r <= `BYTE_ZERO;
        end else if (clk_en && data_we) begin
            if (data_addr == `ADDR_PTR_ONE) ptr_one_r <= data_wdata;
            if (data_addr == `ADDR_PTR_SECOND) ptr_second_r <= data_wdata;
            if (data_addr == `ADDR_SHORT_ONE) short_one_r <= data_wdata;
            if (data_addr == `ADDR_SHORT_SECOND) short_second_r <= data_wdata;
        end
    end

    // access timing: short-direct takes four cycles, others answer next cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cyc_r <= `CYC_ZERO;
            ack_r <= 1'b0;
        end else if (clk_en) begin
            ack_r <= 1'b0;
            if (cyc_r != `CYC_ZERO) begin
                cyc_r <= cyc_r - `CYC_ONE;
                ack_r <= cyc_r == `CYC_ONE + `CYC_ONE;
            end else if (data_re || data_we) begin
                if (short_direct) begin
                    cyc_r <= `SHORT_DIRECT_CYCLES;
                end else begin
                    ack_r <= 1'b1;
                end
            end
        end
    end

    // read data; addresses outside these registers read zero with no hit
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_r <= `BYTE_ZERO;
            hit_r <= 1'b0;
        end else if (clk_en && (data_re || data_we) && cyc_r == `CYC_ZERO) begin
            hit_r <= is_reg;
            case (data_addr)
                `ADDR_SUM: rdata_r <= sum_r;
                `ADDR_PTR_ONE: rdata_r <= ptr_one_r;
                `ADDR_PTR_SECOND: rdata_r <= ptr_second_r;
                `ADDR_SHORT_ONE: rdata_r <= short_one_r;
                `ADDR_SHORT_SECOND: rdata_r <= short_second_r;
                default: rdata_r <= `BYTE_ZERO;
            endcase
        end
    end

    // flag and stack status copies so outputs leave flip-flops
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            carry_r <= 1'b0;
            zero_r <= 1'b0;
            empty_r <= 1'b1;
        end else if (clk_en) begin
            carry_r <= carry_all[ctx_nxt];
            zero_r <= zero_all[ctx_nxt];
            empty_r <= sif.empty;
        end
    end

    assign instr_pointer = ip_r;
    assign prog_page = page_r;
    assign sum_register = sum_r;
    assign data_rdata = rdata_r;
    assign data_hit = hit_r;
    assign data_ack = ack_r;
    assign ctx_state = ctx_r;
    assign carry_flag = carry_r;
    assign zero_flag = zero_r;
    assign stack_empty = empty_r;

    a_ip_step: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && !take_any && ip_op == core_ctx_pkg::op_step |=>
        ip_r == $past(ip_r) + `IP_W'(1))
        else $error("step did not advance pointer by one");
    a_ip_return: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && !take_any && ip_op == core_ctx_pkg::op_back && !sif.empty |=>
        ip_r == $past(sif.top_data))
        else $error("return did not load first stack level");
    a_irq_entry: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && irq_take && !nmi_take |=>
        ip_r == $past(irq_vector) && sif.top_data == $past(ip_r) &&
        ctx_r == core_ctx_pkg::ctx_irq)
        else $error("interrupt entry wrong");
    a_ctx_restore: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && irq_take && !nmi_take ##1 clk_en && !take_any &&
        ip_op == core_ctx_pkg::op_irq_back |=> ctx_r == $past(ctx_r, 2))
        else $error("irq_back did not restore context");
    a_short_four: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && data_re && short_direct && cyc_r == `CYC_ZERO ##1 clk_en[*3] |=>
        ack_r)
        else $error("short direct access not four cycles");
    c_call_ret: cover property (@(posedge sys_clk)
        clk_en && ip_op == core_ctx_pkg::op_call ##[1:8] clk_en && ip_op == core_ctx_pkg::op_back);
    c_nmi_take: cover property (@(posedge sys_clk) clk_en && nmi_take);
    c_short_read: cover property (@(posedge sys_clk) clk_en && data_re && short_direct);
endmodule

// file: hdl/flag_bank.sv
// three carry/zero flag pairs, one per execution context
// assumes the update strobe refers to the active context only
`timescale 1ns/1ns
`include "core_ctx_defs.svh"
module flag_bank (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input core_ctx_pkg::ctx_e ctx,
    input wire logic carry_we,
    input wire logic carry_in,
    input wire logic zero_we,
    input wire logic zero_in,
    output logic carry_out,
    output logic zero_out,
    output logic [2:0] carry_all,
    output logic [2:0] zero_all
);
    logic [2:0] carry_r;
    logic [2:0] zero_r;

    // only the pair of the running context may change; switches touch none
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pair
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    carry_r[g] <= 1'b0;
                    zero_r[g] <= 1'b0;
                end else if (clk_en && (int'(ctx) == g)) begin
                    if (carry_we) carry_r[g] <= carry_in;
                    if (zero_we) zero_r[g] <= zero_in;
                end
            end
        end
    endgenerate

    assign carry_out = carry_r[ctx];
    assign zero_out = zero_r[ctx];
    assign carry_all = carry_r;
    assign zero_all = zero_r;

    a_flag_isolate: assert property (@(posedge sys_clk) disable iff (reset)
        ctx != core_ctx_pkg::ctx_main |=> $stable(carry_r[0]) && $stable(zero_r[0]))
        else $error("main pair changed outside its context");
endmodule

// file: hdl/ret_stack.sv
// six level return stack, shifted with no pointer
// assumes push and pop are never high together
`timescale 1ns/1ns
`include "core_ctx_defs.svh"
module ret_stack (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    stack_if.stack sif
);
    logic [`IP_W-1:0] lvl_r [`STACK_DEPTH];
    logic [`STACK_DEPTH-1:0] used_r;

    // each level shifts deeper on push, up on pop
    genvar g;
    generate
        for (g = 0; g < `STACK_DEPTH; g++) begin : g_lvl
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    lvl_r[g] <= `IP_ZERO;
                    used_r[g] <= 1'b0;
                end else if (clk_en && sif.push) begin
                    lvl_r[g] <= (g == 0) ? sif.push_data : lvl_r[(g == 0) ? 0 : g-1];
                    used_r[g] <= (g == 0) ? 1'b1 : used_r[(g == 0) ? 0 : g-1];
                end else if (clk_en && sif.pop && used_r[0]) begin
                    // empty stack stays at its top position on pop
                    lvl_r[g] <= (g == `STACK_DEPTH-1) ? lvl_r[g] : lvl_r[(g == `STACK_DEPTH-1) ? g : g+1];
                    used_r[g] <= (g == `STACK_DEPTH-1) ? 1'b0 : used_r[(g == `STACK_DEPTH-1) ? g : g+1];
                end
            end
        end
    endgenerate

    assign sif.top_data = lvl_r[0];
    assign sif.empty = ~used_r[0];

    a_stack_fill: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && sif.push |=> !sif.empty && sif.top_data == $past(sif.push_data))
        else $error("push did not land in first level");
    a_stack_deep: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && sif.push && used_r[`STACK_DEPTH-1] |=> used_r[`STACK_DEPTH-1])
        else $error("full stack lost depth on push");
    a_stack_empty: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && sif.pop && sif.empty |=> sif.empty && $stable(sif.top_data))
        else $error("empty stack changed on pop");
endmodule

// file: hdl/stack_if.sv
// carrier between the core top and its return stack
// assumes one clock domain, driven by the core top
`timescale 1ns/1ns
`include "core_ctx_defs.svh"
interface stack_if;
    logic push;
    logic pop;
    logic [`IP_W-1:0] push_data;
    logic [`IP_W-1:0] top_data;
    logic empty;
    modport core (output push, output pop, output push_data, input top_data, input empty);
    modport stack (input push, input pop, input push_data, output top_data, output empty);
endinterface

// file: verification/irq_source.sv
// interrupt logic beside the core: turns bench requests into one-cycle take pulses
// assumes requests are raised just after a rising edge and held for one cycle
`timescale 1ns/1ns
module irq_source #(
    parameter logic [11:0] HANDLER_VEC = 12'h0f0
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic want_irq,
    input wire logic want_nmi,
    output logic irq_take,
    output logic nmi_take,
    output logic [11:0] irq_vector
);
    // registered pulses, one per request, so the core sees them a cycle late
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_take <= 1'b0;
            nmi_take <= 1'b0;
        end else begin
            irq_take <= want_irq;
            nmi_take <= want_nmi;
        end
    end

    // vector only holds while a take is offered; otherwise its inverse, to expose misuse
    assign irq_vector = irq_take ? HANDLER_VEC : ~HANDLER_VEC;
endmodule

// file: verification/tb_cpu_pc_flags_stack.sv
// self-checking bench for the program sequencing and register context block
// assumes the interrupt source model and all design files are compiled first
`timescale 1ns/1ns
`include "core_ctx_defs.svh"
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb_cpu_pc_flags_stack;
    localparam logic [11:0] VEC = 12'h0f0;
    logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
    core_ctx_pkg::ipop_e ip_op = core_ctx_pkg::op_none;
    logic [11:0] target_addr = 12'h000, irq_vector, instr_pointer;
    logic [7:0] branch_offset = 8'h00, sum_in = 8'h00, page_in = 8'h00;
    logic want_irq = 1'b0, want_nmi = 1'b0, irq_take, nmi_take;
    logic carry_we = 1'b0, carry_in = 1'b0, zero_we = 1'b0, zero_in = 1'b0;
    logic sum_we = 1'b0, page_we = 1'b0, data_we = 1'b0, data_re = 1'b0, short_direct = 1'b0;
    logic [7:0] data_addr = 8'h00, data_wdata = 8'h00;
    logic [7:0] prog_page, sum_register, data_rdata;
    logic data_hit, data_ack, carry_flag, zero_flag, stack_empty;
    core_ctx_pkg::ctx_e ctx_state;
    int num_errors = 0, num_checks = 0;
    logic [7:0] map_addr [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};

    irq_source #(.HANDLER_VEC(VEC)) src (.sys_clk(sys_clk), .reset(reset),
        .want_irq(want_irq), .want_nmi(want_nmi), .irq_take(irq_take),
        .nmi_take(nmi_take), .irq_vector(irq_vector));

    cpu_pc_flags_stack dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .ip_op(ip_op), .target_addr(target_addr), .branch_offset(branch_offset),
        .irq_take(irq_take), .nmi_take(nmi_take), .irq_vector(irq_vector),
        .carry_we(carry_we), .carry_in(carry_in), .zero_we(zero_we), .zero_in(zero_in),
        .sum_we(sum_we), .sum_in(sum_in), .page_we(page_we), .page_in(page_in),
        .data_we(data_we), .data_re(data_re), .short_direct(short_direct),
        .data_addr(data_addr), .data_wdata(data_wdata), .instr_pointer(instr_pointer),
        .prog_page(prog_page), .sum_register(sum_register), .data_rdata(data_rdata),
        .data_hit(data_hit), .data_ack(data_ack), .ctx_state(ctx_state),
        .carry_flag(carry_flag), .zero_flag(zero_flag), .stack_empty(stack_empty));

    // 20 MHz core clock
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // one sequencer operation, taken at the next edge
    task automatic op(input core_ctx_pkg::ipop_e o, input logic [11:0] a);
        ip_op = o;
        target_addr = a;
        @(posedge sys_clk);
        ip_op <= core_ctx_pkg::op_none; // released on the edge so a following call may raise it
        #1;
    endtask

    task automatic branch(input logic [7:0] off);
        branch_offset = off;
        op(core_ctx_pkg::op_branch, 12'h000);
    endtask

    // the source model delays by one edge, so entry lands on the second edge
    task automatic take(input logic nmi);
        if (nmi) want_nmi = 1'b1;
        else want_irq = 1'b1;
        @(posedge sys_clk);
        #1 want_irq = 1'b0;
        want_nmi = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic flags(input logic cwe, input logic c, input logic zwe, input logic z);
        carry_we = cwe;
        carry_in = c;
        zero_we = zwe;
        zero_in = z;
        @(posedge sys_clk);
        carry_we <= 1'b0;
        zero_we <= 1'b0;
        // the visible flag copy follows the bank one edge later
        @(posedge sys_clk);
        #1;
    endtask

    // plain data-space access; acknowledge is due right after the request edge
    task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d);
        data_we = we;
        data_re = ~we;
        data_addr = a;
        data_wdata = d;
        @(posedge sys_clk);
        data_we <= 1'b0;
        data_re <= 1'b0;
        #1 `CHECK(data_ack, 1'b1)
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog, far beyond the few dozen cycles the tests need
    initial begin
        #(5000 * 50);
        num_errors++;
        tally_and_finish;
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        #1 reset = 1'b0;
        `CHECK(instr_pointer, `VEC_RESET)
        `CHECK(ctx_state, core_ctx_pkg::ctx_nmi)
        `CHECK(stack_empty, 1'b1)
        // contexts: each pair keeps its values across switches
        flags(1'b1, 1'b1, 1'b1, 1'b1);
        `CHECK({carry_flag, zero_flag}, 2'b11)
        op(core_ctx_pkg::op_irq_back, 12'h000);
        `CHECK(ctx_state, core_ctx_pkg::ctx_main)
        `CHECK(instr_pointer, 12'hfff)
        `CHECK({carry_flag, zero_flag}, 2'b00)
        flags(1'b1, 1'b1, 1'b1, 1'b0);
        take(1'b0);
        `CHECK(ctx_state, core_ctx_pkg::ctx_irq)
        `CHECK(instr_pointer, VEC)
        `CHECK({carry_flag, zero_flag}, 2'b00)
        flags(1'b0, 1'b1, 1'b1, 1'b1);
        `CHECK({carry_flag, zero_flag}, 2'b01)
        take(1'b1);
        `CHECK(ctx_state, core_ctx_pkg::ctx_nmi)
        `CHECK(instr_pointer, `VEC_NMI)
        `CHECK({carry_flag, zero_flag}, 2'b11)
        op(core_ctx_pkg::op_irq_back, 12'h000);
        `CHECK(instr_pointer, VEC)
        `CHECK({ctx_state, carry_flag, zero_flag}, {core_ctx_pkg::ctx_irq, 2'b01})
        op(core_ctx_pkg::op_irq_back, 12'h000);
        `CHECK(instr_pointer, 12'hfff)
        `CHECK({ctx_state, carry_flag, zero_flag}, {core_ctx_pkg::ctx_main, 2'b10})
        // sequencing: step, wrap at 12 bits, branch both ways, held by clk_en
        op(core_ctx_pkg::op_step, 12'h000);
        `CHECK(instr_pointer, 12'h000)
        op(core_ctx_pkg::op_jump, 12'h100);
        `CHECK(instr_pointer, 12'h100)
        branch(8'h05);
        `CHECK(instr_pointer, 12'h105)
        branch(8'hfd);
        `CHECK(instr_pointer, 12'h102)
        branch(8'h80);
        `CHECK(instr_pointer, 12'h082)
        op(core_ctx_pkg::op_step, 12'h000);
        `CHECK(instr_pointer, 12'h083)
        clk_en = 1'b0;
        op(core_ctx_pkg::op_step, 12'h000);
        clk_en = 1'b1;
        `CHECK(instr_pointer, 12'h083)
        // seven nested calls: the oldest return address falls off the bottom
        op(core_ctx_pkg::op_jump, 12'h200);
        for (int i = 0; i < 7; i++) op(core_ctx_pkg::op_call, 12'h300 + 12'(i));
        `CHECK(instr_pointer, 12'h306)
        `CHECK(stack_empty, 1'b0)
        for (int i = 5; i >= 0; i--) begin
            op(core_ctx_pkg::op_back, 12'h000);
            `CHECK(instr_pointer, 12'h300 + 12'(i))
        end
        @(posedge sys_clk);
        #1 `CHECK(stack_empty, 1'b1)
        op(core_ctx_pkg::op_back, 12'h000);
        `CHECK(instr_pointer, 12'h301)
        `CHECK(stack_empty, 1'b1)
        // data-space registers: write all five, read back, then an unmapped place
        for (int i = 0; i < 5; i++) acc(1'b1, map_addr[i], 8'h5a + 8'(i * 17));
        `CHECK(sum_register, 8'h9e)
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, map_addr[i], 8'h00);
            `CHECK({data_hit, data_rdata}, {1'b1, 8'h5a + 8'(i * 17)})
        end
        sum_we = 1'b1;
        sum_in = 8'hc3;
        @(posedge sys_clk);
        #1 sum_we = 1'b0;
        `CHECK(sum_register, 8'hc3)
        acc(1'b0, 8'hff, 8'h00);
        `CHECK(data_rdata, 8'hc3)
        acc(1'b0, 8'h84, 8'h00);
        `CHECK({data_hit, data_rdata}, 9'h000)
        // short-direct read: data early, acknowledge four cycles after the request
        data_re = 1'b1;
        short_direct = 1'b1;
        data_addr = 8'h82;
        @(posedge sys_clk);
        #1 data_re = 1'b0;
        short_direct = 1'b0;
        `CHECK({data_ack, data_rdata}, {1'b0, 8'h7c})
        repeat (2) @(posedge sys_clk);
        #1 `CHECK(data_ack, 1'b0)
        @(posedge sys_clk);
        #1 `CHECK(data_ack, 1'b1)
        @(posedge sys_clk);
        #1 `CHECK(data_ack, 1'b0)
        // interrupt then an immediate irq_back: the pushed pointer and main context return
        take(1'b0);
        `CHECK(instr_pointer, VEC)
        op(core_ctx_pkg::op_irq_back, 12'h000);
        `CHECK({ctx_state, instr_pointer}, {core_ctx_pkg::ctx_main, 12'h301})
        // program page selection for space beyond 4096 bytes
        page_we = 1'b1;
        page_in = 8'ha5;
        @(posedge sys_clk);
        #1 page_we = 1'b0;
        `CHECK(prog_page, 8'ha5)
        `CHECK(instr_pointer, 12'h301)
        tally_and_finish;
    end
endmodule
